// ==== core/scc_params.svh ====
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SCC_CLK_KHZ 25000
`define SCC_RST_HOLD_NS 1000
`define SCC_RST_HOLD_CYC \
	((`SCC_RST_HOLD_NS * `SCC_CLK_KHZ + 999999) / 1000000)
`define SCC_RST_CNT_W 8

// ------------------------------------------------------------
// Regulator setting, 50 mV steps from 2.25 V
// ------------------------------------------------------------
`define SCC_LDO_W 4
`define SCC_LDO_DEF 4'h5
`define SCC_LDO_MAX 4'ha

// ------------------------------------------------------------
// Interrupt source bits
// ------------------------------------------------------------
`define SCC_NINT 7
`define SCC_INT_PLL_LOCK 0
`define SCC_INT_CUR_LIM 1
`define SCC_INT_IOSC_FAIL 2
`define SCC_INT_MOSC_FAIL 3
`define SCC_INT_LOW_VIN 4
`define SCC_INT_LOW_LDO 5
`define SCC_INT_PLL_FAIL 6

// ------------------------------------------------------------
// Reset cause bits
// ------------------------------------------------------------
`define SCC_NRC 5
`define SCC_RC_LOW_VIN 0
`define SCC_RC_LOW_LDO 1
`define SCC_RC_EXT 2
`define SCC_RC_SW 3
`define SCC_RC_WDT 4

// ------------------------------------------------------------
// Misc widths and defaults
// ------------------------------------------------------------
`define SCC_XTAL_W 5
`define SCC_XTAL_DEF 5'h00
`define SCC_NPER_DEF 32
`define SCC_NPER_MAX 32

`endif

// ==== core/scc_pkg.sv ====
package scc_pkg;

	typedef enum logic [1:0] {
		scc_run = 2'b00,
		scc_sleep = 2'b01,
		scc_deep = 2'b11
	} scc_mode_t;

	typedef enum logic [2:0] {
		scc_src_ext = 3'h0,
		scc_src_main = 3'h1,
		scc_src_int = 3'h2,
		scc_src_int4 = 3'h3,
		scc_src_pll = 3'h4
	} scc_src_t;

	typedef enum logic [1:0] {
		scc_ref_ext = 2'h0,
		scc_ref_main = 2'h1,
		scc_ref_int = 2'h2,
		scc_ref_int4 = 2'h3
	} scc_ref_t;

endpackage : scc_pkg

// ==== core/scc_pc_if.sv ====
interface scc_pc_if
	import scc_pkg::*;
#(
	parameter int NPER = 32
);
	scc_mode_t mode;
	logic [NPER-1:0] en_set;
	logic [NPER-1:0] en_clr;
	logic [NPER-1:0] slp_set;
	logic [NPER-1:0] slp_clr;
	logic [NPER-1:0] dslp_set;
	logic [NPER-1:0] dslp_clr;
	logic [NPER-1:0] rst_req;
	logic [NPER-1:0] clk_en;
	logic [NPER-1:0] prst;

	modport top (
		output mode, en_set, en_clr, slp_set, slp_clr,
		output dslp_set, dslp_clr, rst_req,
		input clk_en, prst
	);
	modport ctl (
		input mode, en_set, en_clr, slp_set, slp_clr,
		input dslp_set, dslp_clr, rst_req,
		output clk_en, prst
	);
endinterface : scc_pc_if

// ==== core/scc_periph_ctl.sv ====
module scc_periph_ctl
	import scc_pkg::*;
#(
	parameter int NPER = 32
) (
	input wire logic mclk,
	input wire logic rst,
	scc_pc_if.ctl pc
);
	logic [NPER-1:0] run_q;
	logic [NPER-1:0] slp_q;
	logic [NPER-1:0] dslp_q;
	logic [NPER-1:0] clk_en_q;
	logic [NPER-1:0] prst_q;

	// ------------------------------------------------------------
	// Enable sets, set wins over clear
	// ------------------------------------------------------------
	// run-mode enable and disable
	always_ff @(posedge mclk) begin
		if (rst) begin
			run_q <= '0;
		end else begin
			run_q <= (run_q & ~pc.en_clr) | pc.en_set;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			slp_q <= '0;
		end else begin
			slp_q <= (slp_q & ~pc.slp_clr) | pc.slp_set;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			dslp_q <= '0;
		end else begin
			dslp_q <= (dslp_q & ~pc.dslp_clr) | pc.dslp_set;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			clk_en_q <= '0;
		end else begin
			case (pc.mode)
				scc_run: clk_en_q <= run_q;
				scc_sleep: clk_en_q <= slp_q;
				scc_deep: clk_en_q <= dslp_q;
				default: clk_en_q <= run_q;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			prst_q <= '1;
		end else begin
			prst_q <= pc.rst_req;
		end
	end

	assign pc.clk_en = clk_en_q;
	assign pc.prst = prst_q;
endmodule : scc_periph_ctl

// ==== core/scc_top.sv ====
// Behaviour
// - System clock from one of five sources
// - PLL reference from any of four oscillators
// - Run clocks processor; sleep stops it and switches peripheral clocks to the sleep set
// - Deep sleep: no PLL, crystal clock, CPU stopped
// - Sleep entered by code; interrupt wakes
// - Five events reset the whole device
// - Reset causes recorded, sticky until cleared; some events configurable
// - Per-peripheral enable, disable and reset
// - Separate sleep and deep-sleep enable sets
// - Seven system interrupt sources
// - Per-source enable; sticky until handler clears
// - Read-only memory size and presence info
// - Regulator setting, default 2.5 V
// - Refuse disabling oscillator the requested source needs
`include "scc_params.svh"

module scc_top
	import scc_pkg::*;
#(
	parameter int NPER = `SCC_NPER_DEF,
	parameter logic [15:0] FLASH_KB = 16'h0020,
	parameter logic [15:0] SRAM_KB = 16'h0008,
	parameter logic [NPER-1:0] PERIPH_PRESENT = '1,
	parameter logic [31:0] PIN_PRESENT = 32'h0000_0000,
	parameter int RST_HOLD = `SCC_RST_HOLD_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic clk_cfg_wr,
	input wire scc_src_t clk_cfg_src,
	input wire scc_ref_t clk_cfg_ref,
	input wire logic [`SCC_XTAL_W-1:0] clk_cfg_xtal,
	input wire logic clk_cfg_main_dis,
	input wire logic clk_cfg_int_dis,
	input wire logic sleep_req,
	input wire logic deep_req,
	input wire logic irq_wake,
	input wire logic ev_low_vin,
	input wire logic ev_low_ldo,
	input wire logic ev_ext_rst,
	input wire logic ev_sw_rst,
	input wire logic ev_wdt,
	input wire logic ev_pll_lock,
	input wire logic ev_cur_lim,
	input wire logic ev_iosc_fail,
	input wire logic ev_mosc_fail,
	input wire logic ev_pll_fail,
	input wire logic vin_rst_en,
	input wire logic ldo_rst_en,
	input wire logic [`SCC_NRC-1:0] cause_clr,
	input wire logic [`SCC_NINT-1:0] int_en_set,
	input wire logic [`SCC_NINT-1:0] int_en_clr,
	input wire logic [`SCC_NINT-1:0] int_clr,
	input wire logic ldo_wr,
	input wire logic [`SCC_LDO_W-1:0] ldo_val,
	input wire logic [NPER-1:0] per_en_set,
	input wire logic [NPER-1:0] per_en_clr,
	input wire logic [NPER-1:0] per_slp_set,
	input wire logic [NPER-1:0] per_slp_clr,
	input wire logic [NPER-1:0] per_dslp_set,
	input wire logic [NPER-1:0] per_dslp_clr,
	input wire logic [NPER-1:0] per_rst_req,
	output scc_mode_t mode_q,
	output logic cpu_clk_en_q,
	output scc_src_t sysclk_sel_q,
	output scc_ref_t pll_ref_q,
	output logic pll_pd_q,
	output logic [`SCC_XTAL_W-1:0] xtal_q,
	output logic main_osc_en_q,
	output logic int_osc_en_q,
	output logic cfg_refused_q,
	output logic sys_rst_q,
	output logic [`SCC_NRC-1:0] cause_q,
	output logic [`SCC_NINT-1:0] int_raw_q,
	output logic [`SCC_NINT-1:0] int_en_q,
	output logic [`SCC_NINT-1:0] int_masked_q,
	output logic sys_irq_q,
	output logic [`SCC_LDO_W-1:0] ldo_q,
	output logic [15:0] flash_kb_q,
	output logic [15:0] sram_kb_q,
	output logic [NPER-1:0] periph_present_q,
	output logic [31:0] pin_present_q,
	output logic [NPER-1:0] per_clk_en_q,
	output logic [NPER-1:0] per_rst_q
);
	generate
		if (NPER < 1 || NPER > `SCC_NPER_MAX || RST_HOLD < 1 ||
			RST_HOLD >= (1 << `SCC_RST_CNT_W)) begin : g_bad
			$error("scc_top: unsupported parameter value");
		end
	endgenerate

	// ------------------------------------------------------------
	// Clock configuration
	// ------------------------------------------------------------
	scc_src_t src_q;
	scc_mode_t mode_d;
	logic main_need;
	logic int_need;
	logic refuse_main;
	logic refuse_int;

	// Which oscillators the requested source really needs
	always_comb begin
		main_need = 1'b0;
		int_need = 1'b0;
		case (clk_cfg_src)
			scc_src_ext, scc_src_main: main_need = 1'b1;
			scc_src_int, scc_src_int4: int_need = 1'b1;
			scc_src_pll: begin
				main_need = (clk_cfg_ref == scc_ref_ext) ||
					(clk_cfg_ref == scc_ref_main);
				int_need = (clk_cfg_ref == scc_ref_int) ||
					(clk_cfg_ref == scc_ref_int4);
			end
			default: main_need = 1'b1;
		endcase
	end

	assign refuse_main = clk_cfg_main_dis && main_need;
	assign refuse_int = clk_cfg_int_dis && int_need;

	always_ff @(posedge mclk) begin
		if (rst) begin
			src_q <= scc_src_main;
			pll_ref_q <= scc_ref_main;
			xtal_q <= `SCC_XTAL_DEF;
		end else if (clk_cfg_wr) begin
			src_q <= clk_cfg_src;
			pll_ref_q <= clk_cfg_ref;
			xtal_q <= clk_cfg_xtal;
		end
	end

	// oscillator enables never drop while the requested source needs them
	always_ff @(posedge mclk) begin
		if (rst) begin
			main_osc_en_q <= 1'b1;
			int_osc_en_q <= 1'b1;
			cfg_refused_q <= 1'b0;
		end else begin
			cfg_refused_q <= clk_cfg_wr && (refuse_main || refuse_int);
			if (clk_cfg_wr) begin
				main_osc_en_q <= !clk_cfg_main_dis || main_need;
				int_osc_en_q <= !clk_cfg_int_dis || int_need;
			end
			// Deep sleep runs on the crystal, so keep it alive
			if (mode_d == scc_deep) begin
				main_osc_en_q <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Power mode
	// ------------------------------------------------------------
	logic wake;

	assign wake = irq_wake || (|(int_raw_q & int_en_q));

	// sleep only on request from code
	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			scc_run: begin
				// A pending wake would end the sleep at once
				if (!wake && deep_req) begin
					mode_d = scc_deep;
				end else if (!wake && sleep_req) begin
					mode_d = scc_sleep;
				end
			end
			scc_sleep, scc_deep: begin
				if (wake) begin
					mode_d = scc_run;
				end
			end
			default: mode_d = scc_run;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst || sys_rst_q) begin
			mode_q <= scc_run;
			cpu_clk_en_q <= 1'b1;
		end else begin
			mode_q <= mode_d;
			cpu_clk_en_q <= (mode_d == scc_run);
		end
	end

	// deep sleep: crystal clock, PLL off
	always_ff @(posedge mclk) begin
		if (rst) begin
			sysclk_sel_q <= scc_src_main;
			pll_pd_q <= 1'b1;
		end else if (mode_d == scc_deep) begin
			sysclk_sel_q <= scc_src_main;
			pll_pd_q <= 1'b1;
		end else begin
			sysclk_sel_q <= src_q;
			pll_pd_q <= (src_q != scc_src_pll);
		end
	end

	// ------------------------------------------------------------
	// Device reset and cause record
	// ------------------------------------------------------------
	logic [`SCC_NRC-1:0] rc_ev;
	logic [`SCC_RST_CNT_W-1:0] hold_q;

	// low-voltage resets can be switched off
	assign rc_ev[`SCC_RC_LOW_VIN] = ev_low_vin && vin_rst_en;
	assign rc_ev[`SCC_RC_LOW_LDO] = ev_low_ldo && ldo_rst_en;
	assign rc_ev[`SCC_RC_EXT] = ev_ext_rst;
	assign rc_ev[`SCC_RC_SW] = ev_sw_rst;
	assign rc_ev[`SCC_RC_WDT] = ev_wdt;

	always_ff @(posedge mclk) begin
		if (rst) begin
			hold_q <= '0;
			sys_rst_q <= 1'b0;
		end else if (|rc_ev) begin
			hold_q <= RST_HOLD[`SCC_RST_CNT_W-1:0];
			sys_rst_q <= 1'b1;
		end else if (hold_q != '0) begin
			hold_q <= hold_q - 1'b1;
			sys_rst_q <= (hold_q != `SCC_RST_CNT_W'(1));
		end else begin
			sys_rst_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cause_q <= '0;
		end else begin
			cause_q <= (cause_q & ~cause_clr) | rc_ev;
		end
	end

	// ------------------------------------------------------------
	// System interrupts
	// ------------------------------------------------------------
	logic [`SCC_NINT-1:0] int_ev;
	logic [`SCC_NINT-1:0] raw_d;
	logic [`SCC_NINT-1:0] en_d;

	assign int_ev[`SCC_INT_PLL_LOCK] = ev_pll_lock;
	assign int_ev[`SCC_INT_CUR_LIM] = ev_cur_lim;
	assign int_ev[`SCC_INT_IOSC_FAIL] = ev_iosc_fail;
	assign int_ev[`SCC_INT_MOSC_FAIL] = ev_mosc_fail;
	assign int_ev[`SCC_INT_LOW_VIN] = ev_low_vin;
	assign int_ev[`SCC_INT_LOW_LDO] = ev_low_ldo;
	assign int_ev[`SCC_INT_PLL_FAIL] = ev_pll_fail;

	assign raw_d = (int_raw_q & ~int_clr) | int_ev;
	assign en_d = (int_en_q & ~int_en_clr) | int_en_set;

	always_ff @(posedge mclk) begin
		if (rst) begin
			int_raw_q <= '0;
			int_en_q <= '0;
			int_masked_q <= '0;
			sys_irq_q <= 1'b0;
		end else begin
			int_raw_q <= raw_d;
			int_en_q <= en_d;
			int_masked_q <= raw_d & en_d;
			sys_irq_q <= |(raw_d & en_d);
		end
	end

	// ------------------------------------------------------------
	// Regulator and device information
	// ------------------------------------------------------------
	// out-of-range settings ignored
	always_ff @(posedge mclk) begin
		if (rst) begin
			ldo_q <= `SCC_LDO_DEF;
		end else if (ldo_wr && ldo_val <= `SCC_LDO_MAX) begin
			ldo_q <= ldo_val;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			flash_kb_q <= FLASH_KB;
			sram_kb_q <= SRAM_KB;
			periph_present_q <= PERIPH_PRESENT;
			pin_present_q <= PIN_PRESENT;
		end
	end

	// ------------------------------------------------------------
	// Peripheral gating
	// ------------------------------------------------------------
	scc_pc_if #(.NPER(NPER)) pc ();

	// Absent peripherals are never enabled
	assign pc.mode = mode_q;
	assign pc.en_set = per_en_set & PERIPH_PRESENT;
	assign pc.en_clr = per_en_clr;
	assign pc.slp_set = per_slp_set & PERIPH_PRESENT;
	assign pc.slp_clr = per_slp_clr;
	assign pc.dslp_set = per_dslp_set & PERIPH_PRESENT;
	assign pc.dslp_clr = per_dslp_clr;
	// device reset also resets every peripheral
	assign pc.rst_req = per_rst_req | {NPER{sys_rst_q}};

	scc_periph_ctl #(.NPER(NPER)) u_pctl (
		.mclk(mclk),
		.rst(rst || sys_rst_q),
		.pc(pc.ctl)
	);

	assign per_clk_en_q = pc.clk_en;
	assign per_rst_q = pc.prst;
endmodule : scc_top

// ==== testbench/scc_top_assertions.sv ====
`include "scc_params.svh"

module scc_top_assertions
	import scc_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic clk_cfg_wr,
	input wire scc_src_t clk_cfg_src,
	input wire logic clk_cfg_int_dis,
	input wire logic irq_wake,
	input wire logic ev_wdt,
	input wire logic ldo_wr,
	input wire logic [`SCC_LDO_W-1:0] ldo_val,
	input wire logic [`SCC_NINT-1:0] int_clr,
	input wire scc_mode_t mode_q,
	input wire logic cpu_clk_en_q,
	input wire scc_src_t sysclk_sel_q,
	input wire logic pll_pd_q,
	input wire logic int_osc_en_q,
	input wire logic cfg_refused_q,
	input wire logic sys_rst_q,
	input wire logic [`SCC_NRC-1:0] cause_q,
	input wire logic [`SCC_NINT-1:0] int_raw_q,
	input wire logic [`SCC_NINT-1:0] int_en_q,
	input wire logic [`SCC_NINT-1:0] int_masked_q,
	input wire logic sys_irq_q,
	input wire logic [`SCC_LDO_W-1:0] ldo_q
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_mask_and: assert property (
		int_masked_q == (int_raw_q & int_en_q)) else $error("masked bad");
	a_irq_line: assert property (
		sys_irq_q == (|int_masked_q)) else $error("irq line bad");
	a_raw_sticky: assert property (1'b1 |=>
		(int_raw_q & $past(int_raw_q & ~int_clr)) ==
		$past(int_raw_q & ~int_clr)) else $error("raw bit lost");
	a_cpu_run: assert property (
		cpu_clk_en_q == (mode_q == scc_run)) else $error("cpu clock bad");
	a_deep_xtal: assert property (mode_q == scc_deep |->
		pll_pd_q && sysclk_sel_q == scc_src_main) else $error("deep clk");
	a_wake_run: assert property (mode_q != scc_run && irq_wake
		|=> mode_q == scc_run) else $error("no wake");
	a_wdt_rst: assert property (
		ev_wdt |=> sys_rst_q [*2]) else $error("reset hold short");
	a_wdt_cause: assert property (
		ev_wdt |=> cause_q[`SCC_RC_WDT]) else $error("cause missing");
	a_ldo_load: assert property (ldo_wr && ldo_val <= `SCC_LDO_MAX
		|=> ldo_q == $past(ldo_val)) else $error("ldo not loaded");
	a_keep_osc: assert property (clk_cfg_wr && clk_cfg_int_dis &&
		clk_cfg_src == scc_src_int |=> cfg_refused_q && int_osc_en_q)
		else $error("osc in use disabled");
	a_src_sel: assert property (clk_cfg_wr && mode_q == scc_run
		|=> ##1 (mode_q != scc_run || sysclk_sel_q == $past(clk_cfg_src, 2)))
		else $error("source not applied");
	cover property (mode_q == scc_deep);
	cover property (cfg_refused_q);
	cover property (sys_rst_q && cause_q[`SCC_RC_EXT]);
endmodule : scc_top_assertions

bind scc_top scc_top_assertions u_chk (.mclk(mclk), .rst(rst),
	.clk_cfg_wr(clk_cfg_wr), .clk_cfg_src(clk_cfg_src),
	.clk_cfg_int_dis(clk_cfg_int_dis), .irq_wake(irq_wake), .ev_wdt(ev_wdt),
	.ldo_wr(ldo_wr), .ldo_val(ldo_val), .int_clr(int_clr), .mode_q(mode_q),
	.cpu_clk_en_q(cpu_clk_en_q), .sysclk_sel_q(sysclk_sel_q),
	.pll_pd_q(pll_pd_q), .int_osc_en_q(int_osc_en_q),
	.cfg_refused_q(cfg_refused_q), .sys_rst_q(sys_rst_q), .cause_q(cause_q),
	.int_raw_q(int_raw_q), .int_en_q(int_en_q), .int_masked_q(int_masked_q),
	.sys_irq_q(sys_irq_q), .ldo_q(ldo_q));

// ==== testbench/scc_osc_model.sv ====
module scc_osc_model #(
	parameter int LOCK_CYC = 6
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic pll_pd,
	input wire logic main_en,
	input wire logic kill,
	output logic lock,
	output logic mfail
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt_q;
	always_ff @(posedge mclk) begin
		if (rst || pll_pd) begin
			cnt_q <= 0;
		end else if (cnt_q <= LOCK_CYC) begin
			cnt_q <= cnt_q + 1;
		end
	end
	assign lock = (cnt_q == LOCK_CYC);
	// fails only when the bench kills it
	assign mfail = kill & main_en;
endmodule : scc_osc_model

// ==== testbench/test_system_clock_reset_power_control.sv ====
`include "scc_params.svh"

module test_system_clock_reset_power_control
	import scc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int NP = 8;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic wr, md, id, slp, dp, wake, vre, lre, lwr, ecur, eif, epf, kill;
	logic cpu, pd, mo, io, refd, srst, irq, lock, mf;
	scc_src_t src, sel;
	scc_ref_t rf, pref;
	scc_mode_t mode;
	logic [4:0] xt, xq, rev, cclr, cause, m_cause;
	logic [3:0] lv, ldo;
	logic [6:0] ies, iec, icl, raw, en, msk, m_raw, m_en;
	logic [NP-1:0] pes, pec, pss, psc, pds, pdc, prq, pce, pr, pp;
	logic [15:0] fk, sk;
	logic [31:0] pin, r, r2;
	logic [3:0] lvs [3] = '{4'ha, 4'hb, 4'h0};
	logic [3:0] eld [3] = '{4'ha, 4'ha, 4'h0};
	int n_fail = 0, num_checks = 0, cycles = 0, seed = 17578;

	scc_top #(.NPER(NP), .FLASH_KB(16'h0040), .SRAM_KB(16'h0010),
		.PERIPH_PRESENT(8'h7f), .PIN_PRESENT(32'h0000_00a5), .RST_HOLD(2))
	u_scc_top (.mclk(mclk), .rst(rst), .clk_cfg_wr(wr), .clk_cfg_src(src),
		.clk_cfg_ref(rf), .clk_cfg_xtal(xt), .clk_cfg_main_dis(md),
		.clk_cfg_int_dis(id), .sleep_req(slp), .deep_req(dp), .irq_wake(wake),
		.ev_low_vin(rev[0]), .ev_low_ldo(rev[1]), .ev_ext_rst(rev[2]),
		.ev_sw_rst(rev[3]), .ev_wdt(rev[4]), .ev_pll_lock(lock),
		.ev_cur_lim(ecur), .ev_iosc_fail(eif), .ev_mosc_fail(mf),
		.ev_pll_fail(epf), .vin_rst_en(vre), .ldo_rst_en(lre),
		.cause_clr(cclr), .int_en_set(ies), .int_en_clr(iec), .int_clr(icl),
		.ldo_wr(lwr), .ldo_val(lv), .per_en_set(pes), .per_en_clr(pec),
		.per_slp_set(pss), .per_slp_clr(psc), .per_dslp_set(pds),
		.per_dslp_clr(pdc), .per_rst_req(prq), .mode_q(mode),
		.cpu_clk_en_q(cpu), .sysclk_sel_q(sel), .pll_ref_q(pref),
		.pll_pd_q(pd), .xtal_q(xq), .main_osc_en_q(mo), .int_osc_en_q(io),
		.cfg_refused_q(refd), .sys_rst_q(srst), .cause_q(cause),
		.int_raw_q(raw), .int_en_q(en), .int_masked_q(msk), .sys_irq_q(irq),
		.ldo_q(ldo), .flash_kb_q(fk), .sram_kb_q(sk), .periph_present_q(pp),
		.pin_present_q(pin), .per_clk_en_q(pce), .per_rst_q(pr));
	scc_osc_model u_osc (.mclk(mclk), .rst(rst), .pll_pd(pd), .main_en(mo),
		.kill(kill), .lock(lock), .mfail(mf));

	always #20 mclk = ~mclk;

	task end_sim;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (e !== g) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task cfg(scc_src_t s, logic m, logic i);
		@(posedge mclk);
		wr <= 1'b1;
		src <= s;
		md <= m;
		id <= i;
		@(posedge mclk);
		wr <= 1'b0;
		@(negedge mclk);
	endtask : cfg

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 2000) begin
			n_fail++;
			end_sim();
		end
	end

	// Reference model of status, enables and causes
	always @(posedge mclk) begin
		if (rst) begin
			m_raw <= '0;
			m_en <= '0;
			m_cause <= '0;
		end else begin
			m_raw <= (m_raw & ~icl) | {epf, rev[1:0], mf, eif, ecur, lock};
			m_en <= (m_en & ~iec) | ies;
			m_cause <= (m_cause & ~cclr) | (rev & {3'b111, lre, vre});
		end
	end
	always @(negedge mclk) begin
		if (!rst) begin
			chk("int_raw", m_raw, raw);
			chk("int_en", m_en, en);
			chk("cause", m_cause, cause);
			chk("int_masked", m_raw & m_en, msk);
			chk("sys_irq", |(m_raw & m_en), irq);
		end
	end

	initial begin
		{wr, md, id, slp, dp, wake, vre, lre, lwr, ecur, eif, epf, kill} = '0;
		{xt, rev, cclr, lv, ies, iec, icl} = '0;
		{pes, pec, pss, psc, pds, pdc, prq} = '0;
		src = scc_src_main;
		rf = scc_ref_main;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		@(negedge mclk);
		chk("ldo", `SCC_LDO_DEF, ldo);
		chk("sizes", 32'h0040_0010, {fk, sk});
		chk("present", 8'h7f, pp);
		chk("pins", 32'h0000_00a5, pin);
		repeat (300) begin
			@(posedge mclk);
			r = $random(seed);
			r2 = $random(seed);
			ecur <= &r[1:0];
			eif <= &r[4:2];
			epf <= &r[7:5];
			rev[1:0] <= r[9:8] & r[11:10] & r[13:12];
			{vre, lre} <= r[15:14];
			ies <= r[22:16];
			iec <= r[29:23];
			icl <= r2[6:0] & r2[13:7];
		end
		@(posedge mclk);
		{ecur, eif, epf, rev, ies, iec, icl} <= '0;
		for (int k = 0; k < 5; k++) begin
			@(posedge mclk);
			rf <= scc_ref_t'(k % 4);
			// software picks a valid crystal code
			xt <= 5'(k + 8);
			cfg(scc_src_t'(k), 1'b0, 1'b0);
			@(negedge mclk);
			chk("sysclk", k, sel);
			chk("pll_ref", k % 4, pref);
			chk("xtal", k + 8, xq);
			chk("pll_pd", k != 4, pd);
		end
		repeat (10) @(posedge mclk);
		cfg(scc_src_int, 1'b0, 1'b1);
		chk("refused", {1'b1, 1'b1}, {refd, io});
		cfg(scc_src_main, 1'b0, 1'b1);
		chk("refused", {1'b0, 1'b0}, {refd, io});
		cfg(scc_src_main, 1'b1, 1'b0);
		chk("refused", {1'b1, 1'b1}, {refd, mo});
		@(posedge mclk);
		kill <= 1'b1;
		iec <= 7'h7f;
		icl <= 7'h7f;
		@(posedge mclk);
		{kill, iec, icl} <= '0;
		cfg(scc_src_pll, 1'b0, 1'b0);
		@(posedge mclk);
		{pes, pss, pds, prq} <= {8'hff, 8'h0c, 8'h30, 8'h02};
		@(posedge mclk);
		{pes, pss, pds, prq} <= '0;
		@(negedge mclk);
		chk("per_rst", 8'h02, pr);
		@(negedge mclk);
		chk("per_clk", 8'h7f, pce);
		for (int k = 0; k < 2; k++) begin
			@(posedge mclk);
			slp <= (k == 0);
			dp <= (k == 1);
			@(posedge mclk);
			{slp, dp} <= '0;
			@(negedge mclk);
			chk("mode", k ? scc_deep : scc_sleep, mode);
			chk("cpu_clk", 0, cpu);
			chk("sysclk", k ? scc_src_main : scc_src_pll, sel);
			chk("pll_pd", k, pd);
			@(negedge mclk);
			chk("per_clk", k ? 8'h30 : 8'h0c, pce);
			@(posedge mclk);
			if (k == 0) wake <= 1'b1;
			else {ies, ecur} <= {7'h02, 1'b1};
			@(posedge mclk);
			{wake, ies, ecur} <= '0;
			@(negedge mclk);
			@(negedge mclk);
			chk("mode", scc_run, mode);
		end
		@(posedge mclk);
		slp <= 1'b1;
		@(posedge mclk);
		slp <= 1'b0;
		@(negedge mclk);
		chk("mode", scc_run, mode);
		foreach (lvs[k]) begin
			@(posedge mclk);
			lwr <= 1'b1;
			lv <= lvs[k];
			@(posedge mclk);
			lwr <= 1'b0;
			@(negedge mclk);
			chk("ldo", eld[k], ldo);
		end
		@(posedge mclk);
		{vre, lre} <= 2'b11;
		for (int k = 0; k < 5; k++) begin
			@(posedge mclk);
			rev <= 5'(1 << k);
			@(posedge mclk);
			rev <= '0;
			@(negedge mclk);
			chk("sys_rst", 1, srst);
			repeat (5) @(negedge mclk);
			chk("sys_rst", 0, srst);
			@(posedge mclk);
			cclr <= '1;
			@(posedge mclk);
			cclr <= '0;
		end
		end_sim();
	end
endmodule : test_system_clock_reset_power_control
